// file: hw/rila_pkg.sv
// package for the indirect clock-register gateway: offsets, fields, resets, timing
// assumes a byte-wide special-function register port on the system clock
// Contract
// - key register reads state code 0 locked, 1 awaiting, 2 unlocked, 3 disabled.
// - writing first key then second key from locked unlocks the interface.
// - wrong value while awaiting second key disables until system reset.
// - any key register write while unlocked relocks the interface.
// - key writes while disabled are ignored until system reset.
// - address bit 7 shows busy; writing one starts an indirect read.
// - address bit 6 is the read/write autoread enable.
// - address bit 4 is the read/write short strobe enable.
// - address bits 3:0 select the internal register targeted.
// - address bit 5 reads zero and ignores writes.
// - address auto-increments after accesses to snapshot or alarm bytes.
// - key and address registers reset to zero.
// - a data port write starts an indirect write to the selected register.
// - with autoread on, each data port read starts the next indirect read.
// - indirect access attempted while locked disables the interface.
// - an access takes seven clocks, six with short strobe.
package rila_pkg;
  localparam logic [7:0] RILA_ADDR_CTRL_OFS  = 8'hac;
  localparam logic [7:0] RILA_DATA_OFS       = 8'had;
  localparam logic [7:0] RILA_KEY_OFS        = 8'hae;
  localparam logic [7:0] RILA_KEY_FIRST      = 8'ha5;
  localparam logic [7:0] RILA_KEY_SECOND     = 8'hf1;
  localparam int         RILA_BUSY_BIT       = 7;
  localparam int         RILA_AUTOREAD_ENABLE_BIT     = 6;
  localparam int         RILA_SHORT_BIT      = 4;
  localparam logic [7:0] RILA_ADDR_CTRL_RST  = 8'h00;
  localparam logic [7:0] RILA_DATA_RST       = 8'h00;
  localparam logic [7:0] RILA_ST_LOCKED      = 8'h00;
  localparam logic [7:0] RILA_ST_WAIT2       = 8'h01;
  localparam logic [7:0] RILA_ST_UNLOCKED    = 8'h02;
  localparam logic [7:0] RILA_ST_DISABLED    = 8'h03;
  localparam logic [3:0] RILA_SNAP_LAST      = 4'h3;
  localparam logic [3:0] RILA_ALARM_FIRST    = 4'h8;
  localparam logic [3:0] RILA_ALARM_LAST     = 4'hb;
  localparam logic [3:0] RILA_ACC_LONG_CYC   = 4'h7;
  localparam logic [3:0] RILA_ACC_SHORT_CYC  = 4'h6;
  typedef enum logic [1:0] {RILA_LOCKED, RILA_WAIT2, RILA_UNLOCKED, RILA_DISABLED}
    rila_key_state_type;
endpackage

// file: hw/rila_strobe_if.sv
// carrier between the gateway and its access timer
// assumes both ends share the system clock
interface rila_strobe_if;
  logic       start;
  logic       short_en;
  logic       busy;
  logic       done;
  modport ctrl (output start, output short_en, input busy, input done);
  modport tmr  (input start, input short_en, output busy, output done);
endinterface

// file: hw/rila_access_timer.sv
// access timer: times one indirect transfer, 7 or 6 clocks
// assumes start only while idle
module rila_access_timer
  import rila_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    rst_n_in,
  rila_strobe_if.tmr   strb
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] load_val;

  // ----------------------------------------
  // cycle count
  // ----------------------------------------
  // seven or six clocks
  assign load_val = strb.short_en ? RILA_ACC_SHORT_CYC : RILA_ACC_LONG_CYC;
  assign cnt_next = (strb.start && cnt_reg == 4'h0) ? load_val
                  : (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
  assign strb.busy = (cnt_reg != 4'h0);
  assign strb.done = (cnt_reg == 4'h1);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  end
endmodule // rila_access_timer

// file: hw/rila_gateway.sv
// gateway: key lock, address/control and data port onto internal clock registers
// assumes one byte-wide register write or read strobe per cycle from the processor
module rila_gateway
  import rila_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  input  wire logic [7:0] INT_RDATA_IN,
  output logic      [7:0] REG_RDATA_OUT,
  output logic      [3:0] INT_ADDR_OUT,
  output logic      [7:0] INT_WDATA_OUT,
  output logic            INT_WR_OUT,
  output logic            INT_RD_OUT
);
  rila_key_state_type key_reg;
  rila_key_state_type key_next;
  logic [7:0] addr_ctrl_reg;
  logic [7:0] addr_ctrl_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       op_wr_reg;
  logic       op_wr_next;
  logic [7:0] rdata_next;

  rila_strobe_if strb ();

  rila_access_timer u_timer (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .strb     (strb)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire key_wr   = REG_WR_IN && REG_ADDR_IN == RILA_KEY_OFS;
  wire adr_wr   = REG_WR_IN && REG_ADDR_IN == RILA_ADDR_CTRL_OFS;
  wire dat_wr   = REG_WR_IN && REG_ADDR_IN == RILA_DATA_OFS;
  wire dat_rd   = REG_RD_IN && REG_ADDR_IN == RILA_DATA_OFS;
  wire unlocked = key_reg == RILA_UNLOCKED;
  wire busy     = strb.busy;
  // an accepted control write that also starts an access takes effect at once,
  // so the read strobe never shows a stale target or strobe length
  wire [7:0] ctrl_eff = (unlocked && adr_wr && !busy) ? REG_WDATA_IN : addr_ctrl_reg;
  wire [3:0] sel_addr = addr_ctrl_reg[3:0];
  wire auto_inc = sel_addr <= RILA_SNAP_LAST ||
                  (sel_addr >= RILA_ALARM_FIRST && sel_addr <= RILA_ALARM_LAST);
  wire rd_req = adr_wr && REG_WDATA_IN[RILA_BUSY_BIT];
  wire auto_rd = dat_rd && addr_ctrl_reg[RILA_AUTOREAD_ENABLE_BIT];
  wire any_req = rd_req || auto_rd || dat_wr;
  wire start   = unlocked && !busy && (rd_req || auto_rd || dat_wr);
  wire locked_try = !unlocked && (adr_wr || any_req);

  assign strb.start    = start;
  assign strb.short_en = ctrl_eff[RILA_SHORT_BIT];

  // ----------------------------------------
  // lock and key
  // ----------------------------------------
  always_comb
  begin
    key_next = key_reg;
    if (locked_try && key_reg != RILA_DISABLED)
      key_next = RILA_DISABLED;
    else if (key_wr)
      unique case (key_reg)
        RILA_LOCKED:
          key_next = (REG_WDATA_IN == RILA_KEY_FIRST) ? RILA_WAIT2 : RILA_DISABLED;
        RILA_WAIT2:
          key_next = (REG_WDATA_IN == RILA_KEY_SECOND) ? RILA_UNLOCKED : RILA_DISABLED;
        RILA_UNLOCKED:
          key_next = RILA_LOCKED;
        RILA_DISABLED:
          key_next = RILA_DISABLED;
      endcase
  end

  // ----------------------------------------
  // address/control and data
  // ----------------------------------------
  always_comb
  begin
    addr_ctrl_next = addr_ctrl_reg;
    data_next      = data_reg;
    op_wr_next     = op_wr_reg;
    if (start)
      op_wr_next = dat_wr;
    if (unlocked && adr_wr && !busy)
    begin
      addr_ctrl_next[RILA_AUTOREAD_ENABLE_BIT] = REG_WDATA_IN[RILA_AUTOREAD_ENABLE_BIT];
      addr_ctrl_next[RILA_SHORT_BIT]  = REG_WDATA_IN[RILA_SHORT_BIT];
      addr_ctrl_next[3:0]             = REG_WDATA_IN[3:0];
    end
    if (unlocked && dat_wr && !busy)
      data_next = REG_WDATA_IN;
    if (strb.done)
    begin
      if (!op_wr_reg)
        data_next = INT_RDATA_IN;
      if (auto_inc)
        addr_ctrl_next[3:0] = sel_addr + 4'h1;
    end
    addr_ctrl_next[5] = 1'b0;
    addr_ctrl_next[RILA_BUSY_BIT] = 1'b0;
  end

  wire [7:0] key_code = (key_reg == RILA_LOCKED)   ? RILA_ST_LOCKED
                      : (key_reg == RILA_WAIT2)    ? RILA_ST_WAIT2
                      : (key_reg == RILA_UNLOCKED) ? RILA_ST_UNLOCKED : RILA_ST_DISABLED;
  wire [7:0] adr_view = {strb.busy, addr_ctrl_reg[6:0]};

  always_comb
  begin
    rdata_next = 8'h00;
    if (REG_RD_IN)
      unique case (REG_ADDR_IN)
        RILA_KEY_OFS:       rdata_next = key_code;
        RILA_ADDR_CTRL_OFS: rdata_next = unlocked ? adr_view : 8'h00;
        RILA_DATA_OFS:      rdata_next = unlocked ? data_reg : 8'h00;
        default:            rdata_next = 8'h00;
      endcase
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      key_reg       <= RILA_LOCKED;
      addr_ctrl_reg <= RILA_ADDR_CTRL_RST;
      data_reg      <= RILA_DATA_RST;
      op_wr_reg     <= 1'b0;
    end
    else
    begin
      key_reg       <= key_next;
      addr_ctrl_reg <= addr_ctrl_next;
      data_reg      <= data_next;
      op_wr_reg     <= op_wr_next;
    end
  end

  // ----------------------------------------
  // register read data and internal side, all registered
  // ----------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      REG_RDATA_OUT <= 8'h00;
      INT_ADDR_OUT  <= 4'h0;
      INT_WDATA_OUT <= 8'h00;
      INT_WR_OUT    <= 1'b0;
      INT_RD_OUT    <= 1'b0;
    end
    else
    begin
      REG_RDATA_OUT <= rdata_next;
      INT_WR_OUT    <= strb.done && op_wr_reg;
      INT_RD_OUT    <= start && !dat_wr;
      INT_WDATA_OUT <= data_reg;
      INT_ADDR_OUT  <= ctrl_eff[3:0];
    end
  end
endmodule // rila_gateway

// file: tb/rila_gateway_asserts.sv
// ------------------------------------------------
// port checker for the clock-register gateway
// ------------------------------------------------
// assumes one clock and strobes driven off the edge
module rila_gateway_asserts
(
  input wire logic       CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic       REG_WR_IN,
  input wire logic       REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       INT_WR_OUT,
  input wire logic       INT_RD_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       key_rd_reg;
  logic       dis_reg;
  logic [3:0] wr_age_reg;
  logic [3:0] rd_age_reg;
  wire        data_wr = REG_WR_IN && REG_ADDR_IN == 8'had;
  wire        adr_rd  = REG_RD_IN && REG_ADDR_IN == 8'hac;
  wire        go_rd   = (REG_WR_IN && REG_ADDR_IN == 8'hac && REG_WDATA_IN[7]) ||
                        (REG_RD_IN && REG_ADDR_IN == 8'had);
  // ages saturate so stale counts never wrap into a window
  always_ff @(posedge CLK_IN)
  begin
    key_rd_reg <= RST_N_IN && REG_RD_IN && REG_ADDR_IN == 8'hae;
    dis_reg    <= RST_N_IN && (dis_reg || (key_rd_reg && REG_RDATA_OUT == 8'h03));
    wr_age_reg <= !RST_N_IN ? 4'hf : data_wr ? 4'h0 : wr_age_reg + {3'h0, wr_age_reg != 4'hf};
    rd_age_reg <= !RST_N_IN ? 4'hf : INT_RD_OUT ? 4'h0 : rd_age_reg + {3'h0, rd_age_reg != 4'hf};
  end
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  a_key_range: assert property (key_rd_reg |-> REG_RDATA_OUT < 8'h04)
    else $error("key status out of range");
  a_dis_sticky: assert property (key_rd_reg && dis_reg |-> REG_RDATA_OUT == 8'h03)
    else $error("disabled state left");
  a_bit5_zero: assert property ($past(adr_rd) |-> !REG_RDATA_OUT[5])
    else $error("unused address bit read as one");
  a_busy_held: assert property ($past(adr_rd && rd_age_reg < 4'h4) |-> REG_RDATA_OUT[7])
    else $error("busy clear during access");
  a_rd_start: assert property (INT_RD_OUT |-> $past(go_rd) ##1 !INT_RD_OUT)
    else $error("internal read without a start");
  a_wr_commit: assert property (INT_WR_OUT |-> wr_age_reg inside {[4'h5:4'h9]})
    else $error("internal write at wrong time");
  a_wr_pulse: assert property (INT_WR_OUT |=> !INT_WR_OUT)
    else $error("internal write longer than a cycle");
  a_reset_zero: assert property (disable iff (1'b0)
    !RST_N_IN |=> !INT_WR_OUT && !INT_RD_OUT && REG_RDATA_OUT == 8'h00)
    else $error("outputs not cleared by reset");
  c_commit: cover property (INT_WR_OUT);
  c_read: cover property (INT_RD_OUT);
  c_disabled: cover property (key_rd_reg && REG_RDATA_OUT == 8'h03);
endmodule // rila_gateway_asserts

bind rila_gateway rila_gateway_asserts u_rila_gateway_asserts
(
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .INT_WR_OUT(INT_WR_OUT), .INT_RD_OUT(INT_RD_OUT)
);

// file: tb/test_rila_gateway.sv
// ------------------------------------------------
// self-checking bench for the clock-register gateway
// ------------------------------------------------
// assumes the checker is bound in by its own file
module test_rila_gateway
  import rila_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  irdata = 8'h00;
  logic        rd_q = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  iwdata;
  logic        iwr;
  logic [31:0] seed = 32'h6b61662a;
  logic [7:0]  rd_exp[$];
  logic [7:0]  wr_exp[$];
  logic [3:0]  wa_exp[$];
  logic [3:0]  ra_exp[$];
  logic [7:0]  cy_exp[$];
  logic [3:0]  iaddr;
  logic        ird;
  int          wr_t = 0;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  rila_gateway u_rila_gateway (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .INT_RDATA_IN(irdata),
    .REG_RDATA_OUT(rdata), .INT_ADDR_OUT(iaddr), .INT_WDATA_OUT(iwdata), .INT_WR_OUT(iwr),
    .INT_RD_OUT(ird));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic wrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] n);
    wr_exp.push_back(d);
    wa_exp.push_back(a);
    cy_exp.push_back(n);
    wr(8'had, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    rd_exp.push_back(e);
    @(posedge clk);
    rd_s <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude;
    // a note never answered counts as a miss
    if (rd_exp.size() + wr_exp.size() + wa_exp.size() + ra_exp.size() + cy_exp.size() != 0)
      num_errors++;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    rd_q <= rd_s && rst_n;
    if (wr_s && rst_n && addr == 8'had)
      wr_t = cyc;
    if (rd_q)
      chk("rdata", rd_exp.size() ? rd_exp.pop_front() : 8'hxx, rdata);
    if (iwr)
    begin
      chk("iwdata", wr_exp.size() ? wr_exp.pop_front() : 8'hxx, iwdata);
      chk("waddr", {4'h0, wa_exp.size() ? wa_exp.pop_front() : 4'hx}, {4'h0, iaddr});
      chk("wr_cycles", cy_exp.size() ? cy_exp.pop_front() : 8'hxx, 8'(cyc - wr_t));
    end
    if (ird)
      chk("raddr", {4'h0, ra_exp.size() ? ra_exp.pop_front() : 4'hx}, {4'h0, iaddr});
    if (cyc == 2000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    idle(8);
    rst_n <= 1'b1;
    rd(8'hae, 8'h00);
    rd(8'hac, 8'h00);
    wr(8'hae, RILA_KEY_FIRST);
    rd(8'hae, 8'h01);
    wr(8'hae, RILA_KEY_SECOND);
    rd(8'hae, 8'h02);
    rd(8'hac, 8'h00);
    wr(8'hac, 8'h3f);
    rd(8'hac, 8'h1f);
    wr(8'hac, 8'h4a);
    rd(8'hac, 8'h4a);
    seed = lfsr(seed);
    irdata <= seed[7:0];
    ra_exp.push_back(4'h0);
    wr(8'hac, 8'h90);
    rd(8'hac, 8'h90);
    idle(8);
    rd(8'hac, 8'h11);
    rd(8'had, seed[7:0]);
    wrd(4'h1, seed[15:8], 8'(RILA_ACC_SHORT_CYC) + 8'h01);
    idle(9);
    rd(8'hac, 8'h12);
    wr(8'hac, 8'h05);
    wrd(4'h5, seed[23:16], 8'(RILA_ACC_LONG_CYC) + 8'h01);
    idle(9);
    rd(8'hac, 8'h05);
    irdata <= seed[31:24];
    ra_exp.push_back(4'h8);
    wr(8'hac, 8'hc8);
    idle(9);
    ra_exp.push_back(4'h9);
    rd(8'had, seed[31:24]);
    irdata <= seed[15:8];
    idle(9);
    ra_exp.push_back(4'ha);
    rd(8'had, seed[15:8]);
    idle(9);
    rd(8'hac, 8'h4b);
    wr(8'hae, 8'h5a);
    rd(8'hae, 8'h00);
    wr(8'had, 8'h55);
    rd(8'hae, 8'h03);
    wr(8'hae, RILA_KEY_FIRST);
    rd(8'hae, 8'h03);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(8'hae, 8'h00);
    wr(8'hae, RILA_KEY_FIRST);
    wr(8'hae, 8'h12);
    rd(8'hae, 8'h03);
    idle(4);
    conclude();
  end
endmodule // test_rila_gateway
